// ### meter_core.sv
// Metering core: registers, filters, energy, status pins.
// Assumes ADC words on clk; master clock and serial pins are async.
`timescale 1ns/1ps
module meter_core import meter_pkg::*; #(
    parameter int NO_ZX_LIMIT = NO_ZX_TICKS,
    parameter int SAMPLE_RATE_DIV = SAMPLE_DIV
) (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic                       chipSelectN,
    input  wire logic                       serialClk,
    input  wire logic                       serialDataIn,
    output logic                            serialDataOut,
    output logic                            serialDataOe,
    input  wire logic                       master_clock_in,
    input  wire logic signed [SAMPLE_W-1:0] current_channel_inputs,
    input  wire logic signed [SAMPLE_W-1:0] voltage_channel_inputs,
    output logic                            interrupt_request_n,
    output logic                            irqOe,
    output logic                            sagLowN,
    output logic                            sagOe,
    output logic                            zero_cross_out,
    output logic                            power_pulse_out
);

    localparam int DIV_W = $clog2(SAMPLE_RATE_DIV);
    localparam int ZXC_W = $clog2(NO_ZX_LIMIT + 1);

    // Refuse settings the counters cannot serve
    if (SAMPLE_RATE_DIV < 2 || NO_ZX_LIMIT < 2) begin : g_param_check
        $error("meter_core: parameter below 2");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Helper functions
    function automatic logic [2:0] gainShift(input logic [2:0] code);
        gainShift = (code > 3'd4) ? 3'd4 : code;
    endfunction : gainShift

    function automatic logic [2:0] rangeShift(input logic [1:0] code);
        rangeShift = (code == 2'd3) ? 3'd2 : {1'b0, code};
    endfunction : rangeShift

    function automatic logic signed [WIDE_W-1:0] scaleSample(
        input logic signed [SAMPLE_W-1:0] x,
        input logic        [2:0]          sh
    );
        logic signed [WIDE_W-1:0] ext;
        ext = {{(WIDE_W-SAMPLE_W){x[SAMPLE_W-1]}}, x};
        scaleSample = ext <<< sh;
    endfunction : scaleSample

    ////////////////////////////////////////////////////////////////////////////
    // Serial port
    logic [ADDR_W-1:0]    rdAddr, wrAddr;
    logic                 rdStrobe, wrStrobe;
    logic [DATA_BITS-1:0] wrData, rdData;

    meter_serial_slave u_serial (
        .clk           (clk),
        .rst           (rst),
        .chipSelectN   (chipSelectN),
        .serialClk     (serialClk),
        .serialDataIn  (serialDataIn),
        .rdData        (rdData),
        .rdAddr        (rdAddr),
        .rdStrobe      (rdStrobe),
        .wrStrobe      (wrStrobe),
        .wrAddr        (wrAddr),
        .wrData        (wrData),
        .serialDataOut (serialDataOut),
        .serialDataOe  (serialDataOe)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Master clock edges and sample divider
    logic             mclkS1_reg, mclkS2_reg, mclkPrev_reg;
    logic [DIV_W-1:0] divCnt_reg;

    wire mTick      = mclkS2_reg & ~mclkPrev_reg;                  // R13
    wire sampleTick = mTick && (divCnt_reg == DIV_W'(SAMPLE_RATE_DIV - 1));

    // Two stages, then edge find
    always_ff @(posedge clk) begin
        if (rst) begin
            mclkS1_reg   <= 1'b0;
            mclkS2_reg   <= 1'b0;
            mclkPrev_reg <= 1'b0;
            divCnt_reg   <= '0;
        end else begin
            mclkS1_reg   <= master_clock_in;
            mclkS2_reg   <= mclkS1_reg;
            mclkPrev_reg <= mclkS2_reg;
            if (mTick) begin                                       // R13
                divCnt_reg <= sampleTick ? '0 : divCnt_reg + DIV_W'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Software registers
    logic              modeHpf_reg;
    logic [2:0]        mask_reg;
    logic [7:0]        gain_reg;
    logic [PDIV_W-1:0] pulse_divider_setting_reg;
    logic [15:0]       sagLevel_reg;
    logic [7:0]        sagCycles_reg;

    // Writes from the serial port
    always_ff @(posedge clk) begin
        if (rst) begin
            modeHpf_reg               <= MODE_RST[0];
            mask_reg                  <= MASK_RST;
            gain_reg                  <= GAIN_RST;
            pulse_divider_setting_reg <= PDIV_RST;
            sagLevel_reg              <= SAGLVL_RST;
            sagCycles_reg             <= SAGCYC_RST;
        end else if (wrStrobe) begin
            case (wrAddr)
                ADDR_MODE:   modeHpf_reg               <= wrData[MODE_HPF_BIT];
                ADDR_MASK:   mask_reg                  <= wrData[2:0];
                ADDR_GAIN:   gain_reg                  <= wrData[7:0];
                ADDR_PDIV:   pulse_divider_setting_reg <= wrData[PDIV_W-1:0];
                ADDR_SAGLVL: sagLevel_reg              <= wrData[15:0];
                ADDR_SAGCYC: sagCycles_reg             <= wrData[7:0];
                default:     ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Scaling, current high-pass and phase correction
    logic signed [31:0]       dcAcc_reg;
    logic signed [WIDE_W-1:0] iPrev_reg;

    wire [2:0] iShift = 3'(gainShift(gain_reg[GAIN_CH1_LSB +: 3])
                        + rangeShift(gain_reg[GAIN_RANGE_LSB +: 2]));       // R11
    wire [2:0] vShift = gainShift(gain_reg[GAIN_CH2_LSB +: 3]);              // R12
    wire signed [WIDE_W-1:0] iScaled = scaleSample(current_channel_inputs, iShift);
    wire signed [WIDE_W-1:0] vScaled = scaleSample(voltage_channel_inputs, vShift);
    wire signed [WIDE_W-1:0] dcEst   = dcAcc_reg[HPF_SHIFT +: WIDE_W];
    wire signed [WIDE_W-1:0] hpOut   = modeHpf_reg ? iScaled - dcEst : iScaled; // R15
    wire signed [31:0]       dcNext  = dcAcc_reg + {{(32-WIDE_W){hpOut[WIDE_W-1]}}, hpOut};
    wire signed [WIDE_W-1:0] lagDiff = iPrev_reg - hpOut;
    wire signed [WIDE_W-1:0] iCorr   = hpOut + (lagDiff >>> PHASE_SHIFT);     // R14

    // Filter state advances once per sample
    always_ff @(posedge clk) begin
        if (rst) begin
            dcAcc_reg <= '0;
            iPrev_reg <= '0;
        end else if (sampleTick) begin                             // R13
            if (modeHpf_reg) begin
                dcAcc_reg <= dcNext;                               // R15
            end
            iPrev_reg <= hpOut;                                    // R14
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Active power and energy accumulation
    logic signed [ENERGY_W-1:0] energy_reg;
    logic signed [WIDE_W-1:0]   wave_reg;

    wire signed [2*WIDE_W-1:0]  product    = iCorr * vScaled;
    wire signed [31:0]          power      = product[2*WIDE_W-1:16];
    wire signed [ENERGY_W-1:0]  powerExt   = {{(ENERGY_W-32){power[31]}}, power};
    wire signed [ENERGY_W-1:0]  energyNext = energy_reg + powerExt;
    wire rollEvt = sampleTick && (energy_reg[ENERGY_W-1] == powerExt[ENERGY_W-1])
                   && (energyNext[ENERGY_W-1] != energy_reg[ENERGY_W-1]);    // R07
    wire halfEvt = sampleTick && !energy_reg[ENERGY_W-2] && energyNext[ENERGY_W-2]
                   && !energyNext[ENERGY_W-1];                               // R07
    wire waveEvt = sampleTick;                                               // R07

    // Energy and waveform update each sample
    always_ff @(posedge clk) begin
        if (rst) begin
            energy_reg <= '0;
            wave_reg   <= '0;
        end else if (sampleTick) begin
            energy_reg <= energyNext;
            wave_reg   <= iCorr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status and open-drain request pin
    logic [2:0] status_reg;

    wire [2:0] events     = {waveEvt, halfEvt, rollEvt};
    wire       statusRead = rdStrobe && (wrAddr == ADDR_STATUS);
    wire [2:0] statusNext = (status_reg & ~(statusRead ? status_reg : 3'h0)) | events;

    // Set wins over a read clear
    always_ff @(posedge clk) begin
        if (rst) begin
            status_reg          <= '0;
            irqOe               <= 1'b0;
            interrupt_request_n <= 1'b0;                           // R06
        end else begin
            status_reg <= statusNext;
            irqOe      <= |(statusNext & mask_reg);                // R06 R07
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Zero crossing and sag detection
    logic signed [WIDE_W-1:0] vLpf_reg;
    logic [ZXC_W-1:0]         noZxCnt_reg;
    logic [WIDE_W-1:0]        peak_reg;
    logic [7:0]               lowHalves_reg;

    wire signed [WIDE_W-1:0] vLpfNext = vLpf_reg + ((vScaled - vLpf_reg) >>> ZX_LPF_SHIFT);
    wire              zxNext   = ~vLpfNext[WIDE_W-1];                          // R09
    wire              zxEvt    = sampleTick && (zxNext != zero_cross_out);
    wire [WIDE_W-1:0] vAbs     = vLpfNext[WIDE_W-1] ? WIDE_W'(-vLpfNext) : vLpfNext;
    wire [WIDE_W-1:0] peakNext = (vAbs > peak_reg) ? vAbs : peak_reg;
    wire              halfLow  = peakNext < {{(WIDE_W-16){1'b0}}, sagLevel_reg};
    wire              noZx     = noZxCnt_reg == ZXC_W'(NO_ZX_LIMIT);
    wire              lowSag   = (sagCycles_reg != 8'h00)
                                 && (lowHalves_reg >= sagCycles_reg);
    wire              sagNext  = noZx || lowSag;                               // R08

    // Sign, half-cycle peak and crossing watchdog
    always_ff @(posedge clk) begin
        if (rst) begin
            vLpf_reg       <= '0;
            zero_cross_out <= 1'b0;
            noZxCnt_reg    <= '0;
            peak_reg       <= '0;
            lowHalves_reg  <= '0;
            sagOe          <= 1'b0;
            sagLowN        <= 1'b0;
        end else begin
            if (sampleTick) begin
                vLpf_reg       <= vLpfNext;
                zero_cross_out <= zxNext;                          // R09
                peak_reg       <= zxEvt ? '0 : peakNext;
            end
            if (zxEvt) begin
                noZxCnt_reg <= '0;
                if (halfLow) begin                                 // R08
                    lowHalves_reg <= (lowHalves_reg == 8'hFF) ? lowHalves_reg
                                     : lowHalves_reg + 8'd1;
                end else begin
                    lowHalves_reg <= '0;
                end
            end else if (mTick && !noZx) begin
                noZxCnt_reg <= noZxCnt_reg + ZXC_W'(1);            // R08
            end
            sagOe <= sagNext;                                      // R08
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Energy to pulse frequency conversion
    logic [ENERGY_W-1:0] cfAcc_reg;
    logic [7:0]          pulseCnt_reg;

    wire [ENERGY_W-1:0] posPower  = power[31] ? '0 : ENERGY_W'(power);
    wire [ENERGY_W-1:0] cfSum     = cfAcc_reg + posPower;
    wire [ENERGY_W-1:0] cfThresh  = ENERGY_W'({pulse_divider_setting_reg, {CF_SHIFT{1'b0}}})
                                    + (ENERGY_W'(1) << CF_SHIFT);            // R10
    wire                cfFire    = sampleTick && (cfSum >= cfThresh);
    wire [7:0]          pulseNext = cfFire ? 8'(CF_PULSE_TICKS)
                                    : ((mTick && pulseCnt_reg != 8'h00)
                                       ? pulseCnt_reg - 8'd1 : pulseCnt_reg);

    // One fixed pulse per energy threshold
    always_ff @(posedge clk) begin
        if (rst) begin
            cfAcc_reg       <= '0;
            pulseCnt_reg    <= '0;
            power_pulse_out <= 1'b0;
        end else begin
            if (sampleTick) begin
                cfAcc_reg <= cfFire ? cfSum - cfThresh : cfSum;    // R10
            end
            pulseCnt_reg    <= pulseNext;
            power_pulse_out <= pulseNext != 8'h00;                 // R10
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data selection
    assign rdData = (rdAddr == ADDR_WAVE)   ? wave_reg :
                    (rdAddr == ADDR_MODE)   ? DATA_BITS'(modeHpf_reg) :
                    (rdAddr == ADDR_MASK)   ? DATA_BITS'(mask_reg) :
                    (rdAddr == ADDR_STATUS) ? DATA_BITS'(status_reg) :
                    (rdAddr == ADDR_GAIN)   ? DATA_BITS'(gain_reg) :
                    (rdAddr == ADDR_PDIV)   ? DATA_BITS'(pulse_divider_setting_reg) :
                    (rdAddr == ADDR_SAGLVL) ? DATA_BITS'(sagLevel_reg) :
                    (rdAddr == ADDR_SAGCYC) ? DATA_BITS'(sagCycles_reg) :
                    (rdAddr == ADDR_ENERGY) ? energy_reg[ENERGY_W-1 -: DATA_BITS] :
                    '0;

endmodule : meter_core

// ### meter_pkg.sv
// Constants for the metering port and status pins.
// Assumes one 200 MHz clock; pins are sampled into it.
//
// Overview of operation
// [R01] Chip select low addresses the port; while high the serial bus is ignored.
// [R02] Serial transfers are timed only by the host serial clock.
// [R03] Each outgoing data bit is launched at a serial clock rising edge.
// [R04] Serial data output is released except while driving read data.
// [R05] Each incoming data bit is captured at a serial clock falling edge.
// [R06] Interrupt pin is active low open drain.
// [R07] Interrupt sources: energy rollover, energy half level, new waveform sample; each maskable.
// [R08] Sag pin pulls low on missing zero crossings or low voltage for set half cycles.
// [R09] Zero-cross output follows the sign of the filtered voltage channel.
// [R10] Pulse output frequency follows active power, scaled by the pulse divider setting.
// [R11] Current channel gain 1,2,4,8,16 and full-scale range 1, 0.5, 0.25 V.
// [R12] Voltage channel gain 1,2,4,8,16 with one fixed range.
// [R13] Signal processing is paced by the master clock input.
// [R14] Current channel phase correction cancels the high-pass filter phase lead.
// [R15] Enabled current high-pass filter removes DC offset before the power product.
// [R16] Reset holds all logic, serial port included.
////////////////////////////////////////////////////////////////////////////////
package meter_pkg;

    // Serial frame layout
    localparam int CMD_BITS      = 8;
    localparam int DATA_BITS     = 24;
    localparam int FRAME_BITS    = 32;
    localparam int CMD_WRITE_BIT = 7;
    localparam int ADDR_W        = 4;

    // Register addresses in the command byte
    localparam logic [3:0] ADDR_WAVE    = 4'h0;
    localparam logic [3:0] ADDR_MODE    = 4'h1;
    localparam logic [3:0] ADDR_MASK    = 4'h2;
    localparam logic [3:0] ADDR_STATUS  = 4'h3;
    localparam logic [3:0] ADDR_GAIN    = 4'h4;
    localparam logic [3:0] ADDR_PDIV    = 4'h5;
    localparam logic [3:0] ADDR_SAGLVL  = 4'h6;
    localparam logic [3:0] ADDR_SAGCYC  = 4'h7;
    localparam logic [3:0] ADDR_ENERGY  = 4'h8;

    // Field positions
    localparam int MODE_HPF_BIT   = 0;
    localparam int GAIN_CH1_LSB   = 0;
    localparam int GAIN_RANGE_LSB = 3;
    localparam int GAIN_CH2_LSB   = 5;
    localparam int STAT_ROLL_BIT  = 0;
    localparam int STAT_HALF_BIT  = 1;
    localparam int STAT_WAVE_BIT  = 2;

    // Register widths and reset values
    localparam int PDIV_W = 12;
    localparam logic [0:0]  MODE_RST   = 1'h1;
    localparam logic [2:0]  MASK_RST   = 3'h0;
    localparam logic [7:0]  GAIN_RST   = 8'h00;
    localparam logic [11:0] PDIV_RST   = 12'h000;
    localparam logic [15:0] SAGLVL_RST = 16'h0000;
    localparam logic [7:0]  SAGCYC_RST = 8'h00;

    // Datapath sizes
    localparam int SAMPLE_W = 16;
    localparam int WIDE_W   = 24;
    localparam int ENERGY_W = 40;

    // Timing in master clock edges
    localparam int MASTER_CLK_HZ   = 3_579_545;
    localparam int NO_ZX_MS        = 50;
    localparam int NO_ZX_TICKS     = MASTER_CLK_HZ / 1000 * NO_ZX_MS;
    localparam int SAMPLE_DIV      = 128;
    localparam int CF_PULSE_TICKS  = 64;

    // Filter and scaling shifts
    localparam int HPF_SHIFT    = 8;
    localparam int PHASE_SHIFT  = 4;
    localparam int ZX_LPF_SHIFT = 4;
    localparam int CF_SHIFT     = 16;

endpackage : meter_pkg

// ### meter_serial_slave.sv
// Serial slave: samples the port pins, frames commands.
// Assumes the host clock is far slower than clk.
`timescale 1ns/1ps
module meter_serial_slave import meter_pkg::*; (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 chipSelectN,
    input  wire logic                 serialClk,
    input  wire logic                 serialDataIn,
    input  wire logic [DATA_BITS-1:0] rdData,
    output logic      [ADDR_W-1:0]    rdAddr,
    output logic                      rdStrobe,
    output logic                      wrStrobe,
    output logic      [ADDR_W-1:0]    wrAddr,
    output logic      [DATA_BITS-1:0] wrData,
    output logic                      serialDataOut,
    output logic                      serialDataOe
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic csS1_reg, csS2_reg, sclkS1_reg, sclkS2_reg, sclkPrev_reg;
    logic dinS1_reg, dinS2_reg;

    // Two stages per pin plus edge history
    always_ff @(posedge clk) begin
        if (rst) begin                                            // R16
            csS1_reg     <= 1'b1;
            csS2_reg     <= 1'b1;
            sclkS1_reg   <= 1'b0;
            sclkS2_reg   <= 1'b0;
            sclkPrev_reg <= 1'b0;
            dinS1_reg    <= 1'b0;
            dinS2_reg    <= 1'b0;
        end else begin
            csS1_reg     <= chipSelectN;
            csS2_reg     <= csS1_reg;
            sclkS1_reg   <= serialClk;
            sclkS2_reg   <= sclkS1_reg;
            sclkPrev_reg <= sclkS2_reg;
            dinS1_reg    <= serialDataIn;
            dinS2_reg    <= dinS1_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Edge and phase decode
    logic [5:0]           bitCnt_reg;
    logic [CMD_BITS-2:0]  cmdShift_reg;
    logic [DATA_BITS-1:0] inShift_reg;
    logic [DATA_BITS-1:0] outShift_reg;
    logic                 isRead_reg;

    wire                selected = ~csS2_reg;                         // R01
    wire                sclkRise = sclkS2_reg & ~sclkPrev_reg;       // R02
    wire                sclkFall = ~sclkS2_reg & sclkPrev_reg;       // R02
    wire                inCmd    = bitCnt_reg < 6'(CMD_BITS);
    wire                cmdLast  = bitCnt_reg == 6'(CMD_BITS - 1);
    wire                dataLast = bitCnt_reg == 6'(FRAME_BITS - 1);
    wire [CMD_BITS-1:0] cmdFull  = {cmdShift_reg, dinS2_reg};
    wire                cmdWrite = cmdFull[CMD_WRITE_BIT];
    wire                launch   = sclkRise & isRead_reg & ~inCmd
                                   & (bitCnt_reg < 6'(FRAME_BITS));

    assign rdAddr = cmdFull[ADDR_W-1:0];

    // Capture on falls, launch on rises
    always_ff @(posedge clk) begin
        if (rst || !selected) begin                               // R01 R16
            bitCnt_reg    <= '0;
            cmdShift_reg  <= '0;
            inShift_reg   <= '0;
            outShift_reg  <= '0;
            isRead_reg    <= 1'b0;
            rdStrobe      <= 1'b0;
            wrStrobe      <= 1'b0;
            wrAddr        <= '0;
            wrData        <= '0;
            serialDataOut <= 1'b0;
            serialDataOe  <= 1'b0;                                // R04
        end else begin
            rdStrobe <= 1'b0;
            wrStrobe <= 1'b0;
            if (sclkFall && bitCnt_reg < 6'(FRAME_BITS)) begin    // R05
                bitCnt_reg <= bitCnt_reg + 6'd1;
                if (inCmd) begin
                    cmdShift_reg <= cmdFull[CMD_BITS-2:0];
                end else begin
                    inShift_reg <= {inShift_reg[DATA_BITS-2:0], dinS2_reg};
                end
                if (cmdLast) begin
                    isRead_reg <= ~cmdWrite;
                    wrAddr     <= cmdFull[ADDR_W-1:0];
                    rdStrobe   <= ~cmdWrite;
                    if (!cmdWrite) begin
                        outShift_reg <= rdData;
                    end
                end
                if (dataLast && !isRead_reg) begin
                    wrStrobe <= 1'b1;
                    wrData   <= {inShift_reg[DATA_BITS-2:0], dinS2_reg};
                end
            end
            if (launch) begin                                     // R03
                serialDataOut <= outShift_reg[DATA_BITS-1];
                outShift_reg  <= {outShift_reg[DATA_BITS-2:0], 1'b0};
                serialDataOe  <= 1'b1;                            // R04
            end
        end
    end

endmodule : meter_serial_slave

// ### meter_props.sv
// Checker on the pins of meter_core.
// Assumes a bind into meter_core; one clock.
`timescale 1ns/1ps
module meter_props (
    input wire logic clk,
    input wire logic rst,
    input wire logic chipSelectN,
    input wire logic serialClk,
    input wire logic serialDataOut,
    input wire logic serialDataOe,
    input wire logic interrupt_request_n,
    input wire logic irqOe,
    input wire logic sagLowN,
    input wire logic sagOe,
    input wire logic power_pulse_out
);
    ////////////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Pulse holds eight clocks
    sequence pulseHold;
        power_pulse_out [*8];
    endsequence
    // Launch follows a serial clock rise
    sequence launchAfterRise;
        $past(serialClk, 3) && !$past(serialClk, 9);
    endsequence
    a_reset_quiet: assert property (disable iff (1'b0) rst |=>
        !serialDataOe && !irqOe && !sagOe && !power_pulse_out) else $error("reset drive");
    a_irq_open_drain: assert property (interrupt_request_n == 1'b0)
        else $error("irq high");
    a_sag_open_drain: assert property (sagLowN == 1'b0)
        else $error("sag high");
    a_deselect_release: assert property (chipSelectN [*5] |-> !serialDataOe)
        else $error("drive deselected");
    a_drive_needs_select: assert property (serialDataOe |-> !$past(chipSelectN, 5))
        else $error("drive unselected");
    a_launch_on_rise: assert property (serialDataOe && $changed(serialDataOut) |-> launchAfterRise)
        else $error("data off rise");
    a_enable_on_rise: assert property ($rose(serialDataOe) |-> launchAfterRise)
        else $error("enable off rise");
    a_pulse_width: assert property ($rose(power_pulse_out) |-> pulseHold)
        else $error("pulse too short");
endmodule : meter_props

// ### host_model.sv
// Host master: 8-bit command then 24 data bits, MSB first.
// Assumes xfer starts just after a clk edge.
`timescale 1ns/1ps
module host_model (
    input wire logic clk,
    output logic     chipSelectN,
    output logic     serialClk,
    output logic     serialDataIn,
    input wire logic serialDataOut,
    input wire logic serialDataOe
);
    ////////////////////////////////////////
    // Idle: deselected, clock low
    initial begin
        chipSelectN = 1'b1;
        serialClk = 1'b0;
        serialDataIn = 1'b0;
    end
    // One frame at 125 ns per bit; data moves at rises
    task automatic xfer(input logic [7:0] cmd, input logic [23:0] wd, output logic [23:0] rd);
        logic [31:0] sh;
        sh = {cmd, wd};
        rd = 24'h0;
        chipSelectN <= 1'b0;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 32; i++) begin
            serialClk <= 1'b1;
            serialDataIn <= sh[31-i];
            repeat (13) @(posedge clk);
            serialClk <= 1'b0;
            if (i > 7) rd = {rd[22:0], serialDataOe ? serialDataOut : 1'bx};
            repeat (12) @(posedge clk);
        end
        chipSelectN <= 1'b1;
        serialDataIn <= ~serialDataIn;
        repeat (6) @(posedge clk);
    endtask : xfer
endmodule : host_model

// ### tb.sv
// Bench for meter_core: registers, interrupt, line events, reset.
// Assumes host_model on the pins, short sample and sag counts.
`timescale 1ns/1ps
module tb;
    import meter_pkg::*;
    typedef struct {logic wr; logic [3:0] a; logic [23:0] d, e;} row_t;
    logic clk = 1'b0, rst = 1'b1, mclk = 1'b0, seen;
    logic [15:0] iIn = 16'h4000, vIn = 16'hC000;
    logic csN, sclk, din, dout, oe, irqN, irqOe, sagN, sagOe, zx, cf;
    logic [23:0] rd;
    int errTotal = 0, testsRun = 0, cyc = 0;
    // Open-drain pins with pull-ups
    wire irqLine = irqOe ? irqN : 1'b1;
    wire sagLine = sagOe ? sagN : 1'b1;
    row_t rows[13] = '{'{0, ADDR_MODE, 0, 1}, '{0, ADDR_GAIN, 0, 0}, '{0, ADDR_PDIV, 0, 0},
        '{1, ADDR_GAIN, 24'hFF_FFFF, 24'hFF}, '{1, ADDR_PDIV, 24'hAB_CDEF, 24'hDEF},
        '{1, ADDR_SAGLVL, 24'h12_3456, 24'h3456}, '{1, ADDR_SAGCYC, 24'hFF_FFFF, 24'hFF},
        '{1, 4'hF, 24'h12_3456, 0}, '{1, ADDR_MODE, 0, 0}, '{1, ADDR_GAIN, 0, 0},
        '{1, ADDR_SAGLVL, 0, 0}, '{1, ADDR_SAGCYC, 0, 0}, '{1, ADDR_PDIV, 0, 0}};
    ////////////////////////////////////////
    meter_core #(.NO_ZX_LIMIT(200), .SAMPLE_RATE_DIV(4)) meter_core_inst (.clk(clk),
        .rst(rst), .chipSelectN(csN), .serialClk(sclk), .serialDataIn(din),
        .serialDataOut(dout), .serialDataOe(oe), .master_clock_in(mclk),
        .current_channel_inputs(iIn), .voltage_channel_inputs(vIn),
        .interrupt_request_n(irqN), .irqOe(irqOe), .sagLowN(sagN), .sagOe(sagOe),
        .zero_cross_out(zx), .power_pulse_out(cf));
    host_model host_model_inst (.clk(clk), .chipSelectN(csN), .serialClk(sclk),
        .serialDataIn(din), .serialDataOut(dout), .serialDataOe(oe));
    // Clocks and hang limit
    initial forever #2.5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc % 28 == 27) mclk <= ~mclk;
        if (cyc == 60000) begin
            errTotal++;
            completeRun();
        end
    end
    task automatic check(string n, logic [23:0] e, logic [23:0] g);
        testsRun++;
        if (g !== e) begin
            errTotal++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : check
    task automatic completeRun();
        $display("errors %0d checks %0d", errTotal, testsRun);
        if (errTotal == 0 && testsRun > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : completeRun
    task automatic rdChk(string n, logic [3:0] a, logic [23:0] e);
        host_model_inst.xfer({4'h0, a}, 24'h0, rd);
        check(n, e, rd);
    endtask : rdChk
    task automatic watch(int n);
        repeat (n) begin
            @(posedge clk);
            seen = seen | cf;
        end
    endtask : watch
    // Rows, interrupt, line events, second reset
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        foreach (rows[i]) begin
            if (rows[i].wr) host_model_inst.xfer({4'h8, rows[i].a}, rows[i].d, rd);
            rdChk("register", rows[i].a, rows[i].e);
        end
        host_model_inst.xfer({4'h8, ADDR_MASK}, 24'h4, rd);
        for (int k = 0; k < 600 && irqOe !== 1'b1; k++) @(posedge clk);
        check("irq line", 0, irqLine);
        host_model_inst.xfer({4'h0, ADDR_STATUS}, 24'h0, rd);
        check("wave flag", 1, rd[STAT_WAVE_BIT]);
        host_model_inst.xfer({4'h8, ADDR_MASK}, 24'h0, rd);
        check("irq masked", 1, irqLine);
        seen = 1'b0;
        watch(12000);
        check("sag line", 0, sagLine);
        check("zero cross low", 0, zx);
        check("pulse negative", 0, seen);
        vIn <= 16'h4000;
        watch(6000);
        check("zero cross high", 1, zx);
        check("sag cleared", 1, sagLine);
        check("pulse positive", 1, seen);
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1 check("drive after reset", 0, oe);
        @(posedge clk);
        rdChk("mode after reset", ADDR_MODE, 24'h1);
        completeRun();
    end
endmodule : tb
bind meter_core meter_props meter_props_inst (.clk(clk), .rst(rst), .chipSelectN(chipSelectN),
    .serialClk(serialClk), .serialDataOut(serialDataOut), .serialDataOe(serialDataOe),
    .interrupt_request_n(interrupt_request_n), .irqOe(irqOe), .sagLowN(sagLowN),
    .sagOe(sagOe), .power_pulse_out(power_pulse_out));
